// file: src/bts_pkg.sv
// shared constants and carrier types for the bit-test-and-skip executor
package bts_pkg;

  // instruction word layout: oooo bbba ffff ffff
  localparam int OPC_MSB   = 15;                 // opcode prefix top bit
  localparam int OPC_LSB   = 12;                 // opcode prefix low bit
  localparam int BIT_MSB   = 11;                 // bit index top bit
  localparam int BIT_LSB   = 9;                  // bit index low bit
  localparam int ACC_POS   = 8;                  // access flag position
  localparam int FILE_MSB  = 7;                  // file address top bit
  localparam int FILE_LSB  = 0;                  // file address low bit

  // opcode prefixes of the two instructions
  localparam logic [3:0] OPC_SKIP_IF_CLEAR = 4'hb; // skip when bit is 0
  localparam logic [3:0] OPC_SKIP_IF_SET   = 4'ha; // skip when bit is 1

  // data space shape
  localparam int BANK_W    = 4;                  // bank select width
  localparam int ADDR_W    = 12;                 // full data address width
  localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;  // last low access-bank offset
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;   // bank holding upper access half
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;   // bank holding lower access half

  // instruction cycle timing: four clocks per cycle
  localparam logic [1:0] PH_DECODE  = 2'h0;      // latch and resolve
  localparam logic [1:0] PH_READ    = 2'h1;      // read strobe to data memory
  localparam logic [1:0] PH_PROCESS = 2'h2;      // read data arrives
  localparam logic [1:0] PH_WRITE   = 2'h3;      // results published

  // reset values
  localparam logic [1:0]        PHASE_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 12'h000;

  // decoded instruction fields
  typedef struct packed {
    logic [3:0] opcode;    // prefix
    logic [2:0] bitSel;    // bit under test
    logic       accessSel; // 0 access bank, 1 banked
    logic [7:0] fileAddr;  // file operand
  } bts_insn_t;

  // read request toward data memory
  typedef struct packed {
    logic              rd;   // one-clock read strobe
    logic [ADDR_W-1:0] addr; // resolved data address
  } bts_mem_req_t;

endpackage : bts_pkg

// file: src/bts_addr_resolve.sv
// resolves the file operand into a full data address
`timescale 1ns/1ps
`default_nettype none

module bts_addr_resolve (
  input  wire logic                       sys_clk,     // core clock
  input  wire logic                       rst,         // synchronous reset
  input  wire logic                       loadEn,      // capture a new operand
  input  wire logic [7:0]                 fileAddr,    // operand from the word
  input  wire logic                       accessSel,   // access flag
  input  wire logic [bts_pkg::BANK_W-1:0] bankSel,     // bank select register
  input  wire logic                       extEnable,   // extended set active
  input  wire logic [bts_pkg::ADDR_W-1:0] literalBase, // index pointer base
  output logic      [bts_pkg::ADDR_W-1:0] effAddr_reg, // resolved address
  output logic                            indexed_reg  // indexed mode used
);

  // full address from bank and offset
  function automatic logic [bts_pkg::ADDR_W-1:0] joinAddr(input logic [bts_pkg::BANK_W-1:0] bank,
                                                         input logic [7:0] offs);
    joinAddr = {bank, offs};
  endfunction

  logic lowHalf; // operand falls in the low access half
  assign lowHalf = (fileAddr <= bts_pkg::ACCESS_LOW_LIMIT);

  // address is registered so the read strobe sees a stable value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      effAddr_reg <= bts_pkg::ADDR_RST;
      indexed_reg <= 1'b0;
    end else if (loadEn) begin
      indexed_reg <= 1'b0;
      if (accessSel) begin
        effAddr_reg <= joinAddr(bankSel, fileAddr); // RL6
      end else if (extEnable && lowHalf) begin
        // offset wraps within the data space, as the pointer arithmetic does
        effAddr_reg <= literalBase + {4'h0, fileAddr}; // RL7
        indexed_reg <= 1'b1; // RL7
      end else if (lowHalf) begin
        effAddr_reg <= joinAddr(bts_pkg::ACCESS_LOW_BANK, fileAddr); // RL5
      end else begin
        effAddr_reg <= joinAddr(bts_pkg::ACCESS_HIGH_BANK, fileAddr); // RL5
      end
    end
  end

endmodule // bts_addr_resolve

`default_nettype wire

// file: src/bts_exec.sv
// decode and execute of the two bit-test-and-skip instructions
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - clear variant skips when tested bit is 0
// RL2 - set variant skips when tested bit is 1
// RL3 - skip discards prefetched word, runs no-operation
// RL4 - one cycle normally, two when skipping
// RL5 - access flag 0 selects access bank
// RL6 - access flag 1 uses bank select register
// RL7 - extended set, offsets up to 5Fh indexed
// RL8 - decode by prefix, fields; flags untouched
module bts_exec (
  input  wire logic                       sys_clk,      // core clock, 100 MHz
  input  wire logic                       rst,          // synchronous, active high
  input  wire logic                       insnValid,    // instruction word offered
  input  wire logic [15:0]                insnWord,     // instruction word
  input  wire logic [bts_pkg::BANK_W-1:0] bankSel,      // bank select register
  input  wire logic                       extEnable,    // extended set enabled
  input  wire logic [bts_pkg::ADDR_W-1:0] literalBase,  // index pointer base
  input  wire logic [7:0]                 memRdData,    // read data, clock after strobe
  output logic                            insnAccept,   // word taken this clock
  output logic                            cycleStart,   // first clock of a cycle
  output bts_pkg::bts_mem_req_t           memReq,       // read request
  output logic                            busy,         // executing or skipping
  output logic                            skipTaken_reg,    // pulse: skip decided
  output logic                            discardFetch_reg, // pulse: drop prefetched word
  output logic                            nopActive_reg,    // level: substituted no-op cycle
  output logic                            insnDone_reg,     // pulse: instruction retired
  output logic                            testedBit_reg,    // value of bit under test
  output logic                            indexedUsed   // indexed addressing used
);

  // execution states, one per instruction cycle
  typedef enum logic [1:0] {
    BTS_IDLE,  // waiting for an instruction at a cycle start
    BTS_EXEC,  // the one execution cycle
    BTS_NOP    // substituted no-operation after a skip
  } bts_state_t;

  bts_state_t          state_reg;    // current state
  bts_state_t          state_next;   // next state
  logic [1:0]          phase_reg;    // quarter of the instruction cycle
  bts_pkg::bts_insn_t  insnIn;       // fields of the offered word
  bts_pkg::bts_insn_t  insn_reg;     // fields of the executing word
  logic                isBitTest;    // offered word is one of ours
  logic                skipNow;      // skip condition at process phase
  logic                skip_reg;     // skip remembered for write phase
  logic [bts_pkg::ADDR_W-1:0] effAddr; // resolved operand address
  logic                memRd_reg;    // read strobe

  // pick the selected bit out of a byte
  function automatic logic pickBit(input logic [7:0] data, input logic [2:0] sel);
    pickBit = data[sel];
  endfunction

  // field split of the offered word
  assign insnIn.opcode    = insnWord[bts_pkg::OPC_MSB:bts_pkg::OPC_LSB];   // RL8
  assign insnIn.bitSel    = insnWord[bts_pkg::BIT_MSB:bts_pkg::BIT_LSB];   // RL8
  assign insnIn.accessSel = insnWord[bts_pkg::ACC_POS];                    // RL8
  assign insnIn.fileAddr  = insnWord[bts_pkg::FILE_MSB:bts_pkg::FILE_LSB]; // RL8

  // only the two prefixes are ours; other words are left to other decoders
  assign isBitTest = (insnIn.opcode == bts_pkg::OPC_SKIP_IF_CLEAR) ||
                     (insnIn.opcode == bts_pkg::OPC_SKIP_IF_SET); // RL8

  // phase divider: one instruction cycle every four clocks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_reg <= bts_pkg::PHASE_RST;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign cycleStart = (phase_reg == bts_pkg::PH_DECODE);

  // taking a word only at a cycle start keeps the four phases aligned
  assign insnAccept = cycleStart && insnValid && isBitTest &&
                      ((state_reg == BTS_IDLE) ||
                       (state_reg == BTS_EXEC && !skip_reg));

  // operand address resolution
  bts_addr_resolve u_resolve (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .loadEn      (insnAccept),
    .fileAddr    (insnIn.fileAddr),
    .accessSel   (insnIn.accessSel),
    .bankSel     (bankSel),
    .extEnable   (extEnable),
    .literalBase (literalBase),
    .effAddr_reg (effAddr),
    .indexed_reg (indexedUsed)
  );

  // hold the executing word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      insn_reg <= '0;
    end else if (insnAccept) begin
      insn_reg <= insnIn;
    end
  end

  // read strobe in the clock after the word is taken, the read phase;
  // launching it from the accept keeps data in step with the process phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memRd_reg <= 1'b0;
    end else begin
      memRd_reg <= insnAccept;
    end
  end

  assign memReq.rd   = memRd_reg;
  assign memReq.addr = effAddr;

  // skip condition from the byte that was read
  always_comb begin
    skipNow = 1'b0;
    case (insn_reg.opcode)
      bts_pkg::OPC_SKIP_IF_CLEAR: skipNow = !pickBit(memRdData, insn_reg.bitSel); // RL1
      bts_pkg::OPC_SKIP_IF_SET:   skipNow =  pickBit(memRdData, insn_reg.bitSel); // RL2
      default:                    skipNow = 1'b0;
    endcase
  end

  // capture the tested bit and the decision when data is valid
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_reg      <= 1'b0;
      testedBit_reg <= 1'b0;
    end else if (state_reg == BTS_EXEC && phase_reg == bts_pkg::PH_PROCESS) begin
      skip_reg      <= skipNow;
      testedBit_reg <= pickBit(memRdData, insn_reg.bitSel);
    end else if (state_reg != BTS_EXEC) begin
      skip_reg      <= 1'b0;
    end
  end

  // state steps at the last clock of a cycle, or at the cycle start clock when a word is taken
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BTS_IDLE: begin
        if (insnAccept) begin
          state_next = BTS_EXEC;
        end
      end
      BTS_EXEC: begin
        if (phase_reg == bts_pkg::PH_WRITE) begin
          state_next = skip_reg ? BTS_NOP : BTS_IDLE; // RL4
        end
      end
      BTS_NOP: begin
        if (phase_reg == bts_pkg::PH_WRITE) begin
          state_next = BTS_IDLE; // RL4
        end
      end
      default: state_next = BTS_IDLE;
    endcase
    // a back-to-back word restarts execution at the cycle start
    if (insnAccept) begin
      state_next = BTS_EXEC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= BTS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // result pulses at the end of the execution cycle; no status flag is written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skipTaken_reg    <= 1'b0;
      discardFetch_reg <= 1'b0;
    end else begin
      // decided from the fresh read data, since skip_reg is only loaded at this same edge
      skipTaken_reg    <= (state_reg == BTS_EXEC) && (phase_reg == bts_pkg::PH_PROCESS) && skipNow;
      discardFetch_reg <= (state_reg == BTS_EXEC) && (phase_reg == bts_pkg::PH_PROCESS) && skipNow; // RL3
    end
  end

  // no-op level covers the whole second cycle of a skip
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nopActive_reg <= 1'b0;
    end else begin
      nopActive_reg <= (state_next == BTS_NOP); // RL3
    end
  end

  // retire pulse: end of cycle one without skip, end of cycle two with skip
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      insnDone_reg <= 1'b0;
    end else begin
      insnDone_reg <= (phase_reg == bts_pkg::PH_WRITE) &&
                      ((state_reg == BTS_EXEC && !skip_reg) || state_reg == BTS_NOP); // RL4
    end
  end

  assign busy = (state_reg != BTS_IDLE);

endmodule // bts_exec

`default_nettype wire

// file: verification/bts_exec_assertions.sv
// port-level assertion checker for the bit-test-and-skip executor
`timescale 1ns/1ps
`default_nettype none
module bts_exec_checker (
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire logic                       insnValid,
  input wire logic [15:0]                insnWord,
  input wire logic [bts_pkg::BANK_W-1:0] bankSel,
  input wire logic                       extEnable,
  input wire logic [bts_pkg::ADDR_W-1:0] literalBase,
  input wire logic [7:0]                 memRdData,
  input wire logic                       insnAccept,
  input wire logic                       cycleStart,
  input wire bts_pkg::bts_mem_req_t      memReq,
  input wire logic                       busy,
  input wire logic                       skipTaken_reg,
  input wire logic                       discardFetch_reg,
  input wire logic                       nopActive_reg,
  input wire logic                       insnDone_reg,
  input wire logic                       testedBit_reg,
  input wire logic                       indexedUsed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [2:0] selReg; // bit index of the word in flight
  logic       clrReg; // word in flight is the clear variant
  logic       rdDly;  // read strobe one clock late, marks data clock
  logic       expSkip; // skip expected from the data now on the bus
  wire  [7:0] fileOp = insnWord[7:0]; // file operand of the offered word
  // capture the fields of an accepted word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      selReg <= 3'h0;
      clrReg <= 1'b0;
    end else if (insnAccept) begin
      selReg <= insnWord[11:9];
      clrReg <= (insnWord[15:12] == bts_pkg::OPC_SKIP_IF_CLEAR);
    end
  end
  // delay the strobe so the data clock is known
  always_ff @(posedge sys_clk) begin
    rdDly <= rst ? 1'b0 : memReq.rd;
  end
  // polarity of the skip depends on the variant
  always_comb expSkip = clrReg ? !memRdData[selReg] : memRdData[selReg];
  property p_accept_rule;
    insnAccept |-> cycleStart && insnValid && !nopActive_reg &&
      (insnWord[15:12] == bts_pkg::OPC_SKIP_IF_CLEAR || insnWord[15:12] == bts_pkg::OPC_SKIP_IF_SET);
  endproperty
  a_accept_rule: assert property (p_accept_rule) else $error("word taken when it should be refused");
  property p_read_follows; insnAccept |=> memReq.rd ##1 !memReq.rd; endproperty
  a_read_follows: assert property (p_read_follows) else $error("no single read strobe after accept");
  property p_skip_polarity; rdDly |=> skipTaken_reg == $past(expSkip); endproperty
  a_skip_polarity: assert property (p_skip_polarity) else $error("skip decision wrong for tested bit");
  property p_tested_bit; rdDly |=> testedBit_reg == $past(memRdData[selReg]); endproperty
  a_tested_bit: assert property (p_tested_bit) else $error("tested bit not the addressed bit");
  property p_discard_pair; skipTaken_reg == discardFetch_reg; endproperty
  a_discard_pair: assert property (p_discard_pair) else $error("discard not paired with skip");
  property p_nop_cycle; skipTaken_reg |=> nopActive_reg [*4] ##1 (!nopActive_reg && insnDone_reg); endproperty
  a_nop_cycle: assert property (p_nop_cycle) else $error("skip did not add one no-op cycle");
  property p_noskip_done; rdDly ##1 !skipTaken_reg |=> insnDone_reg && !nopActive_reg; endproperty
  a_noskip_done: assert property (p_noskip_done) else $error("plain instruction not done in one cycle");
  property p_access_bank;
    insnAccept && !insnWord[8] && !(extEnable && fileOp <= 8'h5f) |=>
      memReq.addr == {($past(fileOp) <= 8'h5f) ? 4'h0 : 4'hf, $past(fileOp)};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");
  property p_banked; insnAccept && insnWord[8] |=> memReq.addr == {$past(bankSel), $past(fileOp)}; endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");
  property p_indexed;
    insnAccept && !insnWord[8] && extEnable && fileOp <= 8'h5f |=>
      memReq.addr == $past(literalBase) + {4'h0, $past(fileOp)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed literal offset address wrong");
  c_skip: cover property (skipTaken_reg);
  c_back_to_back: cover property (insnDone_reg && insnAccept);
  c_indexed: cover property (insnAccept && extEnable && !insnWord[8] && fileOp <= 8'h5f);
endmodule // bts_exec_checker
`default_nettype wire

// file: verification/bts_mem_model.sv
// banked data memory seen by the executor, fixed content pattern
`timescale 1ns/1ps
`default_nettype none
module bts_mem_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire bts_pkg::bts_mem_req_t memReq,
  output logic [7:0]                 memRdData
);
  // data in the clock after the strobe; otherwise the bus keeps changing
  // so a late sample cannot pass by luck
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memRdData <= 8'h5a;
    end else if (memReq.rd) begin
      memRdData <= memReq.addr[7:0] ^ memReq.addr[11:4];
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule // bts_mem_model
`default_nettype wire

// file: verification/bts_exec_tb.sv
// self-checking bench for the bit-test-and-skip executor
`timescale 1ns/1ps
`default_nettype none
module bts_exec_tb;
  logic sys_clk, rst, insnValid, extEnable;
  logic [15:0] insnWord;
  logic [3:0] bankSel;
  logic [11:0] literalBase;
  logic [7:0] memRdData;
  logic insnAccept, cycleStart, busy, skipTaken_reg, discardFetch_reg;
  logic nopActive_reg, insnDone_reg, testedBit_reg, indexedUsed;
  bts_pkg::bts_mem_req_t memReq;
  int fail_count = 0;
  int n_checks = 0;
  logic [15:0] w;
  logic [15:0] corner [5] = '{16'hb05f, 16'hae60, 16'hb1ff, 16'ha5a5, 16'h7123};
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  bts_exec i_bts_exec (.sys_clk, .rst, .insnValid, .insnWord, .bankSel, .extEnable, .literalBase, .memRdData,
    .insnAccept, .cycleStart, .memReq, .busy, .skipTaken_reg, .discardFetch_reg, .nopActive_reg,
    .insnDone_reg, .testedBit_reg, .indexedUsed);
  bts_mem_model i_bts_mem_model (.sys_clk, .rst, .memReq, .memRdData);
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // address the rules give for a word under the present bank and mode inputs
  function automatic logic [11:0] exp_addr(input logic [15:0] x);
    if (x[8]) return {bankSel, x[7:0]};
    if (extEnable && x[7:0] <= 8'h5f) return literalBase + {4'h0, x[7:0]};
    return {(x[7:0] <= 8'h5f) ? 4'h0 : 4'hf, x[7:0]};
  endfunction
  // offer one word, entered at a falling edge, left at a falling edge
  task run(input logic [15:0] x);
    logic [11:0] a;
    logic [7:0] d;
    logic b, sk, good;
    int n;
    n = 0;
    while (!(cycleStart === 1'b1 && nopActive_reg === 1'b0) && n < 20) begin
      insnValid = 1'b1;
      insnWord = x;
      #1;
      chk(insnAccept === 1'b0, "word taken off the cycle boundary");
      n++;
      @(negedge sys_clk);
    end
    a = exp_addr(x);
    d = a[7:0] ^ a[11:4];
    b = d[x[11:9]];
    sk = (x[15:12] == bts_pkg::OPC_SKIP_IF_CLEAR) ? !b : b;
    good = x[15:12] == bts_pkg::OPC_SKIP_IF_CLEAR || x[15:12] == bts_pkg::OPC_SKIP_IF_SET;
    insnValid = 1'b1;
    insnWord = x;
    #1;
    chk(n < 20 && insnAccept === good, "accept wrong");
    @(negedge sys_clk);
    insnValid = 1'b0;
    if (good) begin
      chk(memReq.rd === 1'b1 && memReq.addr === a, "read address wrong");
      chk(busy === 1'b1 && indexedUsed === (!x[8] && extEnable && x[7:0] <= 8'h5f), "indexed flag wrong");
      repeat (2) @(negedge sys_clk);
      chk(skipTaken_reg === sk && discardFetch_reg === sk && testedBit_reg === b, "skip decision wrong");
      @(negedge sys_clk);
      chk(insnDone_reg === !sk && nopActive_reg === sk && busy === sk, "cycle count wrong");
      if (sk) begin
        insnValid = 1'b1;
        #1;
        chk(insnAccept === 1'b0, "word taken during no-op cycle");
        @(negedge sys_clk);
        insnValid = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(insnDone_reg === 1'b1 && nopActive_reg === 1'b0, "skip length wrong");
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    insnValid = 1'b0;
    insnWord = 16'h0000;
    bankSel = 4'h3;
    extEnable = 1'b1;
    literalBase = 12'hff0;
    void'($urandom(32'h62d8));
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    foreach (corner[i]) run(corner[i]);
    repeat (90) begin
      bankSel = 4'($urandom);
      extEnable = 1'($urandom);
      literalBase = 12'($urandom);
      w = 16'($urandom);
      w[15:12] = ($urandom % 6 == 0) ? 4'($urandom) : (($urandom % 2) ? 4'ha : 4'hb);
      if ($urandom % 4 == 0) @(negedge sys_clk);
      run(w);
    end
    stop_test;
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
endmodule // bts_exec_tb
bind bts_exec bts_exec_checker i_bts_exec_checker (.sys_clk, .rst, .insnValid, .insnWord, .bankSel, .extEnable,
  .literalBase, .memRdData, .insnAccept, .cycleStart, .memReq, .busy, .skipTaken_reg, .discardFetch_reg,
  .nopActive_reg, .insnDone_reg, .testedBit_reg, .indexedUsed);
`default_nettype wire
